// file: tpp_consts.svh
`ifndef TPP_CONSTS_SVH
`define TPP_CONSTS_SVH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define TPP_ENTRIES    64
`define TPP_IDX_W      6
`define TPP_TAG_W      40
`define TPP_W1_W       26
`define TPP_W2_W       15
`define TPP_PAR_W      8
`define TPP_WORD_W     44
`define TPP_TAG_SLICE  10
`define TPP_W1_HALF    13
`define TPP_W2_LO      8

// ----------------------------------------
// parity field positions in a word image
// ----------------------------------------
`define TPP_TAG_PARITY_FIELD_LSB   40
`define TPP_W1PAR_LSB  26
`define TPP_W2PAR_LSB  15

// ----------------------------------------
// parity vector layout and word selects
// ----------------------------------------
`define TPP_PV_TAG     8'h0F
`define TPP_PV_W1      8'h30
`define TPP_PV_W2      8'hC0
`define TPP_WS_TAG     2'h0
`define TPP_WS_W1      2'h1
`define TPP_WS_W2      2'h2

// ----------------------------------------
// permission bits inside word 2 data
// ----------------------------------------
`define TPP_UX_BIT     5
`define TPP_SX_BIT     4
`define TPP_UW_BIT     3
`define TPP_SW_BIT     2
`define TPP_UR_BIT     1
`define TPP_SR_BIT     0

// ----------------------------------------
// state and status registers
// ----------------------------------------
`define TPP_ME_BIT     17
`define TPP_ST_SUM     0
`define TPP_ST_TRANSLATION_PARITY_ERROR_FLAG    1
`define TPP_ST_IMPRECISE_CHECK_FLAG    2
`define TPP_ST_RESET   3'h0
`define TPP_MSW_RESET  32'h0000_0000
`define TPP_ADDR_RESET 32'h0000_0000

`endif

// file: tpp_core_model.sv
`timescale 1ns/1ps

// ----
// pipeline stand-in: oldest uncommitted pc steps every cycle
// ----
module tpp_core_model (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  output logic      [31:0] oldestPc
);
  logic [31:0] pc_r;
  logic [31:0] pc_nxt;

  assign pc_nxt   = pc_r + 32'h0000_0004;
  assign oldestPc = pc_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) pc_r <= 32'h0000_1000;
    else pc_r <= pc_nxt;
  end
endmodule : tpp_core_model

// file: tpp_ent_if.sv
`timescale 1ns/1ps
`include "tpp_consts.svh"

interface tpp_ent_if;
  logic [`TPP_TAG_W-1:0] tag;
  logic [`TPP_W1_W-1:0]  w1;
  logic [`TPP_W2_W-1:0]  w2;
  logic [`TPP_PAR_W-1:0] par;
  logic [`TPP_PAR_W-1:0] chkEn;
  logic                  err;

  modport gen (input tag, input w1, input w2, output par);
  modport chk (input tag, input w1, input w2, input par, input chkEn, output err);
endinterface : tpp_ent_if

// file: tpp_par_chk.sv
`timescale 1ns/1ps
`include "tpp_consts.svh"

module tpp_par_chk (
  tpp_ent_if.chk ent
);
  wire logic [`TPP_PAR_W-1:0] expPar = tpp_pkg::calc_par(ent.tag, ent.w1, ent.w2);

  // any enabled bit off even parity is an error
  assign ent.err = |((expPar ^ ent.par) & ent.chkEn);
endmodule : tpp_par_chk

// file: tpp_par_gen.sv
`timescale 1ns/1ps
`include "tpp_consts.svh"

module tpp_par_gen (
  tpp_ent_if.gen          ent,
  input  wire logic [3:0] injectMask
);
  // inject bit i hits tag bit i and, for i below 2, half i of both data words
  wire logic [`TPP_PAR_W-1:0] injVec = {injectMask[1:0], injectMask[1:0], injectMask};

  assign ent.par = tpp_pkg::calc_par(ent.tag, ent.w1, ent.w2) ^ injVec;
endmodule : tpp_par_gen

// file: tpp_pkg.sv
`include "tpp_consts.svh"

package tpp_pkg;

  typedef enum logic [2:0] {
    TPP_OP_WRITE,
    TPP_OP_READ,
    TPP_OP_SEARCH,
    TPP_OP_REFILL_I,
    TPP_OP_REFILL_D
  } tpp_op_t;

  typedef enum logic [1:0] {
    TPP_ACC_EXEC,
    TPP_ACC_LOAD,
    TPP_ACC_STORE
  } tpp_acc_t;

  // even parity of every protected group, tag slices then word halves
  function automatic logic [`TPP_PAR_W-1:0] calc_par(
    input logic [`TPP_TAG_W-1:0] t,
    input logic [`TPP_W1_W-1:0]  a,
    input logic [`TPP_W2_W-1:0]  b
  );
    logic [`TPP_PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < 4; i++) begin
      p[i] = ^t[i*`TPP_TAG_SLICE +: `TPP_TAG_SLICE];
    end
    p[4] = ^a[`TPP_W1_HALF-1:0];
    p[5] = ^a[`TPP_W1_W-1:`TPP_W1_HALF];
    p[6] = ^b[`TPP_W2_LO-1:0];
    p[7] = ^b[`TPP_W2_W-1:`TPP_W2_LO];
    return p;
  endfunction : calc_par

  // parity bits that belong to one entry word
  function automatic logic [`TPP_PAR_W-1:0] ws_mask(input logic [1:0] ws);
    logic [`TPP_PAR_W-1:0] m;
    m = '0;
    if (ws == `TPP_WS_TAG) m = `TPP_PV_TAG;
    else if (ws == `TPP_WS_W1) m = `TPP_PV_W1;
    else if (ws == `TPP_WS_W2) m = `TPP_PV_W2;
    return m;
  endfunction : ws_mask

endpackage : tpp_pkg

// file: tpp_tb_top.sv
`timescale 1ns/1ps

module tpp_tb_top;
  localparam logic [39:0] T  = 40'hC3_5A96_0F1E;
  localparam logic [25:0] W1 = 26'h2AB_CDEF;
  logic ref_clk, reset_n, opValid, opSearchHit, opUserMode, stateWrValid;
  logic readParityExpose, parityRecoverEnable, respValid, respParityErr, flushReq;
  logic checkTake, instrStorageInt, dataStorageInt;
  tpp_pkg::tpp_op_t  opKind;
  tpp_pkg::tpp_acc_t opAccKind;
  logic [5:0]  opIndex;
  logic [1:0]  opWordSel;
  logic [43:0] opWrData, respData;
  logic [31:0] oldestInstrAddr, stateWrData, checkSaveAddress, checkSaveState;
  logic [31:0] machineStateWord;
  logic [2:0]  statusClear, checkStatusReg;
  logic [3:0]  parityInjectMask, m;
  logic [14:0] w2;
  logic [7:0]  p;
  int          fails, n_checks, cyc;

  tpp_top tpp_top_i (.ref_clk, .reset_n, .opValid, .opKind, .opIndex, .opWordSel, .opWrData,
    .opSearchHit, .opAccKind, .opUserMode, .oldestInstrAddr, .stateWrValid, .stateWrData,
    .statusClear, .readParityExpose, .parityRecoverEnable, .parityInjectMask, .respValid,
    .respData, .respParityErr, .flushReq, .checkTake, .instrStorageInt, .dataStorageInt,
    .checkStatusReg, .checkSaveAddress, .checkSaveState, .machineStateWord);
  tpp_core_model tpp_core_model_i (.ref_clk, .reset_n, .oldestPc(oldestInstrAddr));

  always #25 ref_clk = ~ref_clk;

  // ----
  // hang guard: whole run is about 140 cycles
  // ----
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task chk(input string nm, input logic [43:0] e, input logic [43:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  function logic [7:0] ep(input logic [14:0] b);
    for (int i = 0; i < 4; i++) ep[i] = ^T[i*10 +: 10];
    ep[4] = ^W1[12:0];
    ep[5] = ^W1[25:13];
    ep[6] = ^b[7:0];
    ep[7] = ^b[14:8];
  endfunction : ep

  function logic [43:0] ex(input logic [1:0] ws, input logic [7:0] q);
    if (ws == 2'h0) ex = {q[3:0], T};
    else if (ws == 2'h1) ex = {16'h0, q[5:4], W1};
    else ex = {27'h0, q[7:6], w2};
  endfunction : ex

  // one-cycle request; returns just after the taking edge, answer visible
  task op(input tpp_pkg::tpp_op_t k, input logic [5:0] ix, input logic [1:0] ws);
    @(posedge ref_clk);
    opValid   <= 1'b1;
    opKind    <= k;
    opIndex   <= ix;
    opWordSel <= ws;
    opWrData  <= (ws == 2'h0) ? {4'hF, T} : (ws == 2'h1) ? {16'h0, 2'h3, W1} : {27'h0, 2'h3, w2};
    @(posedge ref_clk);
    opValid <= 1'b0;
    #1;
  endtask : op

  // parity positions carry ones on purpose; they must be ignored
  task wr3(input logic [5:0] ix);
    for (int ws = 0; ws < 3; ws++) begin
      op(tpp_pkg::TPP_OP_WRITE, ix, 2'(ws));
      chk("respValid", 44'h1, respValid);
    end
  endtask : wr3

  task rd(input logic [5:0] ix, input logic [1:0] ws, input logic e, input logic [7:0] q);
    op(tpp_pkg::TPP_OP_READ, ix, ws);
    chk("respParityErr", e, respParityErr);
    chk("respData", ex(ws, q), respData);
  endtask : rd

  task pulse(input logic me);
    @(posedge ref_clk);
    stateWrValid <= me;
    statusClear  <= me ? 3'h0 : 3'h7;
    @(posedge ref_clk);
    stateWrValid <= 1'b0;
    statusClear  <= 3'h0;
  endtask : pulse

  initial begin
    {ref_clk, reset_n, opValid, stateWrValid, readParityExpose, parityRecoverEnable} = '0;
    {opSearchHit, opUserMode} = 2'h3;
    {opIndex, opWordSel, opWrData, statusClear, parityInjectMask} = '0;
    opKind = tpp_pkg::TPP_OP_READ;
    opAccKind = tpp_pkg::TPP_ACC_EXEC;
    stateWrData = 32'h0002_0000;
    w2 = 15'h5A3F;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk("machineStateWord", 44'h0, machineStateWord);
    @(posedge ref_clk) readParityExpose <= 1'b1;
    wr3(6'h05);
    p = ep(w2);
    for (int ws = 0; ws < 3; ws++) rd(6'h05, 2'(ws), 1'b0, p);
    @(posedge ref_clk) readParityExpose <= 1'b0;
    rd(6'h05, 2'h1, 1'b0, 8'h00);
    op(tpp_pkg::TPP_OP_SEARCH, 6'h05, 2'h0);
    chk("respValid", 44'h1, respValid);
    op(tpp_pkg::TPP_OP_REFILL_I, 6'h05, 2'h0);
    chk("respValid", 44'h1, respValid);
    w2 = 15'h5A00;
    wr3(6'h06);
    @(posedge ref_clk) opAccKind <= tpp_pkg::TPP_ACC_LOAD;
    op(tpp_pkg::TPP_OP_REFILL_D, 6'h06, 2'h0);
    chk("dataStorageInt", 44'h1, dataStorageInt);
    @(posedge ref_clk) opAccKind <= tpp_pkg::TPP_ACC_STORE;
    opUserMode <= 1'b0;
    op(tpp_pkg::TPP_OP_REFILL_D, 6'h06, 2'h0);
    chk("dataStorageInt", 44'h1, dataStorageInt);
    @(posedge ref_clk) opAccKind <= tpp_pkg::TPP_ACC_EXEC;
    opUserMode <= 1'b1;
    op(tpp_pkg::TPP_OP_REFILL_I, 6'h06, 2'h0);
    chk("instrStorageInt", 44'h1, instrStorageInt);
    // ----
    // fault injection with machine checks off
    // ----
    w2 = 15'h5A3F;
    @(posedge ref_clk) readParityExpose <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      m = 4'h1 << i;
      parityInjectMask <= m;
      wr3(6'h08);
      @(posedge ref_clk) parityInjectMask <= 4'h0;
      rd(6'h08, 2'h0, 1'b1, {p[7:4], p[3:0] ^ m});
      chk("checkStatusReg", 44'h7, checkStatusReg);
      pulse(1'b0);
      rd(6'h08, 2'h1, i < 2, {p[7:6], p[5:4] ^ m[1:0], p[3:0]});
      pulse(1'b0);
    end
    // search without a hit checks nothing, even on a bad tag
    @(posedge ref_clk) opSearchHit <= 1'b0;
    op(tpp_pkg::TPP_OP_SEARCH, 6'h08, 2'h0);
    chk("respParityErr", 44'h0, respParityErr);
    @(posedge ref_clk) opSearchHit <= 1'b1;
    // ----
    // machine checks on: recoverable, deferred, refill
    // ----
    pulse(1'b1);
    parityRecoverEnable <= 1'b1;
    op(tpp_pkg::TPP_OP_READ, 6'h08, 2'h0);
    chk("respValid", 44'h0, respValid);
    chk("respData", 44'h0, respData);
    chk("checkStatusReg", 44'h3, checkStatusReg);
    chk("checkTake", 44'h1, checkTake);
    chk("machineStateWord", 44'h0, machineStateWord);
    chk("checkSaveState", 44'h2_0000, checkSaveState);
    chk("checkSaveAddress", oldestInstrAddr - 32'h0000_0004, checkSaveAddress);
    pulse(1'b1);
    parityRecoverEnable <= 1'b0;
    op(tpp_pkg::TPP_OP_SEARCH, 6'h08, 2'h0);
    chk("flushReq", 44'h1, flushReq);
    chk("checkTake", 44'h0, checkTake);
    @(posedge ref_clk);
    #1;
    chk("checkTake", 44'h1, checkTake);
    pulse(1'b1);
    op(tpp_pkg::TPP_OP_REFILL_D, 6'h08, 2'h0);
    chk("flushReq", 44'h1, flushReq);
    repeat (2) @(posedge ref_clk);
    pulse(1'b0);
    wr3(6'h09);
    @(posedge ref_clk) parityInjectMask <= 4'h1;
    op(tpp_pkg::TPP_OP_WRITE, 6'h09, 2'h2);
    @(posedge ref_clk) parityInjectMask <= 4'h0;
    op(tpp_pkg::TPP_OP_SEARCH, 6'h09, 2'h0);
    chk("respParityErr", 44'h0, respParityErr);
    rd(6'h09, 2'h1, 1'b0, p);
    op(tpp_pkg::TPP_OP_REFILL_I, 6'h09, 2'h0);
    chk("respParityErr", 44'h1, respParityErr);
    close_out();
  end
endmodule : tpp_tb_top

// file: tpp_top.sv
// Overview of operation
// - array of 64 entries: 40 tag, 41 data, 8 parity bits each
// - parity fields: 4 bits for tag, 2 for word 1, 2 for word 2
// - no detection of multiple tag hits
// - parity computed and stored on every entry write, the only update path
// - each stored parity bit is even parity; checker expects even
// - shadow refill checks tag and both data words
// - search checks only tag parity of the matching entry
// - entry read checks only the selected word
// - mismatch raises machine check; taken only when enable bit set
// - expose bit set: entry read returns stored parity bits
// - parity error sets summary and translation parity flags
// - taking machine check vectors handler and clears enable bit
// - recoverability set: interrupt precedes read completion, target untouched
// - error while disabled also sets imprecise flag
// - error while disabled: read completes with data and parity
// - save address gets oldest uncommitted pc, save state gets old state
// - search or read causing machine check is flushed
// - refill hitting parity error with enable bit set flushes its instruction
// - 4-bit inject mask inverts computed parity on writes
// - no hardware reference or change recording
// - cleared permission bit raises instruction or data storage interrupt
// - expose bit clear: read returns zeros in parity positions
// - write ignores source parity positions, stores computed parity
`timescale 1ns/1ps
`include "tpp_consts.svh"

module tpp_top (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic                   opValid,
  input  wire tpp_pkg::tpp_op_t       opKind,
  input  wire logic [`TPP_IDX_W-1:0]  opIndex,
  input  wire logic [1:0]             opWordSel,
  input  wire logic [`TPP_WORD_W-1:0] opWrData,
  input  wire logic                   opSearchHit,
  input  wire tpp_pkg::tpp_acc_t      opAccKind,
  input  wire logic                   opUserMode,
  input  wire logic [31:0]            oldestInstrAddr,
  input  wire logic                   stateWrValid,
  input  wire logic [31:0]            stateWrData,
  input  wire logic [2:0]             statusClear,
  input  wire logic                   readParityExpose,
  input  wire logic                   parityRecoverEnable,
  input  wire logic [3:0]             parityInjectMask,
  output logic                        respValid,
  output logic [`TPP_WORD_W-1:0]      respData,
  output logic                        respParityErr,
  output logic                        flushReq,
  output logic                        checkTake,
  output logic                        instrStorageInt,
  output logic                        dataStorageInt,
  output logic [2:0]                  checkStatusReg,
  output logic [31:0]                 checkSaveAddress,
  output logic [31:0]                 checkSaveState,
  output logic [31:0]                 machineStateWord
);

  // ----------------------------------------
  // entry storage
  // ----------------------------------------
  // plain arrays, no reset: software must write an entry before use
  logic [`TPP_TAG_W-1:0] tagMem [`TPP_ENTRIES];
  logic [`TPP_W1_W-1:0]  w1Mem  [`TPP_ENTRIES];
  logic [`TPP_W2_W-1:0]  w2Mem  [`TPP_ENTRIES];
  logic [`TPP_PAR_W-1:0] parMem [`TPP_ENTRIES];

  tpp_ent_if genIf ();
  tpp_ent_if chkIf ();

  logic                   respValid_r;
  logic [`TPP_WORD_W-1:0] respData_r;
  logic                   respParityErr_r;
  logic                   flushReq_r;
  logic                   checkTake_r;
  logic                   deferTake_r;
  logic                   instrInt_r;
  logic                   dataInt_r;
  logic [2:0]             status_r;
  logic [2:0]             status_nxt;
  logic [31:0]            saveAddr_r;
  logic [31:0]            saveState_r;
  logic [31:0]            msw_r;
  logic [31:0]            msw_nxt;

  // ----------------------------------------
  // operation decode
  // ----------------------------------------
  wire logic isWrite   = opValid && (opKind == tpp_pkg::TPP_OP_WRITE);
  wire logic isRead    = opValid && (opKind == tpp_pkg::TPP_OP_READ);
  wire logic isSearch  = opValid && (opKind == tpp_pkg::TPP_OP_SEARCH);
  wire logic isRefillI = opValid && (opKind == tpp_pkg::TPP_OP_REFILL_I);
  wire logic isRefillD = opValid && (opKind == tpp_pkg::TPP_OP_REFILL_D);
  wire logic isRefill  = isRefillI || isRefillD;

  wire logic [`TPP_TAG_W-1:0] rdTag = tagMem[opIndex];
  wire logic [`TPP_W1_W-1:0]  rdW1  = w1Mem[opIndex];
  wire logic [`TPP_W2_W-1:0]  rdW2  = w2Mem[opIndex];
  wire logic [`TPP_PAR_W-1:0] rdPar = parMem[opIndex];

  wire logic [`TPP_PAR_W-1:0] wsBits = tpp_pkg::ws_mask(opWordSel);

  // ----------------------------------------
  // write path
  // ----------------------------------------
  // source parity positions are never looked at, only data fields
  wire logic selTag = (opWordSel == `TPP_WS_TAG);
  wire logic selW1  = (opWordSel == `TPP_WS_W1);
  wire logic selW2  = (opWordSel == `TPP_WS_W2);

  wire logic [`TPP_TAG_W-1:0] newTag =
    selTag ? opWrData[`TPP_TAG_W-1:0] : rdTag;
  wire logic [`TPP_W1_W-1:0] newW1 =
    selW1 ? opWrData[`TPP_W1_W-1:0] : rdW1;
  wire logic [`TPP_W2_W-1:0] newW2 =
    selW2 ? opWrData[`TPP_W2_W-1:0] : rdW2;

  assign genIf.tag = newTag;
  assign genIf.w1  = newW1;
  assign genIf.w2  = newW2;

  // ----------------------------------------
  // write-side bundle: generator only, no check
  // ----------------------------------------
  assign genIf.chkEn = '0;
  assign genIf.err   = 1'b0;

  tpp_par_gen u_gen (
    .ent        (genIf.gen),
    .injectMask (parityInjectMask)
  );

  // only the written word's parity bits are replaced
  wire logic [`TPP_PAR_W-1:0] newPar = (genIf.par & wsBits) | (rdPar & ~wsBits);

  // the write instruction is the sole writer: nothing records use
  always_ff @(posedge ref_clk) begin
    if (isWrite) begin
      tagMem[opIndex] <= newTag;
      w1Mem[opIndex]  <= newW1;
      w2Mem[opIndex]  <= newW2;
      parMem[opIndex] <= newPar;
    end
  end

  // ----------------------------------------
  // check path
  // ----------------------------------------
  // search trusts the supplied match index; no multi-hit logic exists
  wire logic searchChk = isSearch && opSearchHit;

  wire logic [`TPP_PAR_W-1:0] chkSel =
    isRefill  ? {`TPP_PAR_W{1'b1}} :
    searchChk ? `TPP_PV_TAG        :
    isRead    ? wsBits             :
    '0;

  assign chkIf.tag   = rdTag;
  assign chkIf.w1    = rdW1;
  assign chkIf.w2    = rdW2;
  assign chkIf.par   = rdPar;
  assign chkIf.chkEn = chkSel;

  tpp_par_chk u_chk (
    .ent (chkIf.chk)
  );

  wire logic parErr  = chkIf.err;
  wire logic meSet   = msw_r[`TPP_ME_BIT];
  wire logic mcCause = parErr && meSet;
  // recoverable mode takes the interrupt alongside the flushed response
  wire logic takeNow = (mcCause && parityRecoverEnable) || deferTake_r;
  wire logic deferSet = mcCause && !parityRecoverEnable;

  // ----------------------------------------
  // read data image
  // ----------------------------------------
  wire logic [`TPP_PAR_W-1:0] shownPar = readParityExpose ? rdPar : '0;

  wire logic [`TPP_WORD_W-1:0] img0 = {shownPar[3:0], rdTag};
  wire logic [`TPP_WORD_W-1:0] img1 =
    {{(`TPP_WORD_W-`TPP_W1_W-2){1'b0}}, shownPar[5:4], rdW1};
  wire logic [`TPP_WORD_W-1:0] img2 =
    {{(`TPP_WORD_W-`TPP_W2_W-2){1'b0}}, shownPar[7:6], rdW2};

  wire logic [`TPP_WORD_W-1:0] readImg =
    selTag ? img0 : selW1 ? img1 : selW2 ? img2 : '0;

  // ----------------------------------------
  // access control on refill
  // ----------------------------------------
  wire logic permExec  = opUserMode ? rdW2[`TPP_UX_BIT] : rdW2[`TPP_SX_BIT];
  wire logic permLoad  = opUserMode ? rdW2[`TPP_UR_BIT] : rdW2[`TPP_SR_BIT];
  wire logic permStore = opUserMode ? rdW2[`TPP_UW_BIT] : rdW2[`TPP_SW_BIT];

  wire logic permOk =
    (opAccKind == tpp_pkg::TPP_ACC_EXEC)  ? permExec  :
    (opAccKind == tpp_pkg::TPP_ACC_LOAD)  ? permLoad  :
    (opAccKind == tpp_pkg::TPP_ACC_STORE) ? permStore : 1'b0;

  // parity error outranks the permission fault
  wire logic accFault = isRefill && !parErr && !permOk;

  // ----------------------------------------
  // status and state words
  // ----------------------------------------
  wire logic [2:0] stSet = {
    parErr && !meSet,
    parErr,
    parErr
  };

  // a new error wins over a clear in the same cycle
  assign status_nxt = (status_r & ~statusClear) | stSet;

  always_comb begin
    msw_nxt = msw_r;
    if (stateWrValid) begin
      msw_nxt = stateWrData;
    end
    if (takeNow) begin
      msw_nxt[`TPP_ME_BIT] = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= `TPP_ST_RESET;
      msw_r    <= `TPP_MSW_RESET;
    end else begin
      status_r <= status_nxt;
      msw_r    <= msw_nxt;
    end
  end

  // a deferred take trails its flush by one cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      checkTake_r <= 1'b0;
      deferTake_r <= 1'b0;
    end else begin
      checkTake_r <= takeNow;
      deferTake_r <= deferSet;
    end
  end

  // ----------------------------------------
  // machine check save registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      saveAddr_r  <= `TPP_ADDR_RESET;
      saveState_r <= `TPP_MSW_RESET;
    end else if (takeNow) begin
      saveAddr_r  <= oldestInstrAddr;
      saveState_r <= msw_r;
    end
  end

  // ----------------------------------------
  // response registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      respValid_r     <= 1'b0;
      respData_r      <= '0;
      respParityErr_r <= 1'b0;
      flushReq_r      <= 1'b0;
    end else begin
      // an instruction that brings a machine check never completes
      respValid_r     <= opValid && !mcCause;
      respData_r      <= (isRead && !mcCause) ? readImg : '0;
      respParityErr_r <= parErr;
      flushReq_r      <= mcCause;
    end
  end

  // storage interrupts only ever come from a refill
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      instrInt_r <= 1'b0;
      dataInt_r  <= 1'b0;
    end else begin
      instrInt_r <= accFault && isRefillI;
      dataInt_r  <= accFault && isRefillD;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign respValid        = respValid_r;
  assign respData         = respData_r;
  assign respParityErr    = respParityErr_r;
  assign flushReq         = flushReq_r;
  assign checkTake        = checkTake_r;
  assign instrStorageInt  = instrInt_r;
  assign dataStorageInt   = dataInt_r;
  assign checkStatusReg   = status_r;
  assign checkSaveAddress = saveAddr_r;
  assign checkSaveState   = saveState_r;
  assign machineStateWord = msw_r;

endmodule : tpp_top

// file: tpp_top_checker.sv
`timescale 1ns/1ps

module tpp_top_checker (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        opValid,
  input wire logic [31:0] oldestInstrAddr,
  input wire logic        respValid,
  input wire logic        respParityErr,
  input wire logic        flushReq,
  input wire logic        checkTake,
  input wire logic        instrStorageInt,
  input wire logic        dataStorageInt,
  input wire logic [2:0]  checkStatusReg,
  input wire logic [31:0] checkSaveState,
  input wire logic [31:0] checkSaveAddress,
  input wire logic [31:0] machineStateWord
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_op_gets_answer: assert property ($past(opValid) |->
    respValid || flushReq || instrStorageInt || dataStorageInt) else $error("op lost");
  a_flush_drops_resp: assert property (flushReq |-> !respValid)
    else $error("flushed op completed");
  a_flush_needs_me: assert property (flushReq |->
    respParityErr && $past(machineStateWord[17])) else $error("bad flush");
  a_err_sets_flags: assert property (respParityErr |->
    checkStatusReg[1:0] == 2'h3) else $error("status flags missing");
  a_imprecise_flag: assert property (respParityErr && !$past(machineStateWord[17])
    |-> checkStatusReg[2] && respValid) else $error("imprecise flag missing");
  a_flush_then_take: assert property (flushReq |-> ##[0:1] checkTake)
    else $error("take missing");
  a_take_from_flush: assert property (checkTake |-> flushReq || $past(flushReq))
    else $error("spurious take");
  a_take_saves_state: assert property (checkTake |-> !machineStateWord[17] &&
    checkSaveState == $past(machineStateWord)) else $error("state save wrong");
  a_take_saves_pc: assert property (checkTake |->
    checkSaveAddress == $past(oldestInstrAddr)) else $error("address save wrong");

  cover property (flushReq ##1 checkTake);
  cover property (respParityErr && respValid);
  cover property (dataStorageInt);
endmodule : tpp_top_checker

bind tpp_top tpp_top_checker tpp_top_checker_i (.ref_clk, .reset_n, .opValid,
  .oldestInstrAddr, .respValid, .respParityErr, .flushReq, .checkTake, .instrStorageInt,
  .dataStorageInt, .checkStatusReg, .checkSaveState, .checkSaveAddress, .machineStateWord);
